// >>> usart_irq_mask_control.sv
// Purpose: Interrupt enable, disable and mask views of a serial port.
// Assumes: Status flags and the mode field come from logic on clk.
// Notes: One mask register serves both layouts; the mode picks the live bits.
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "usart_irq_cfg.svh"
module usart_irq_mask_control import usart_irq_pkg::*; (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,

    // Avalon-MM register slave.
    input wire logic [31:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,

    // Operating mode field of the mode register.
    input wire logic [3:0] usartMode,

    // Channel status flags, levels.
    input wire logic receiverReady,
    input wire logic transmitterReady,
    input wire logic receiveBreak,
    input wire logic receiveBufferEnd,
    input wire logic transmitBufferEnd,
    input wire logic overrun,
    input wire logic stopBitError,
    input wire logic parityError,
    input wire logic rxIdleTimeout,
    input wire logic transmitterEmpty,
    input wire logic transmitBufferEmpty,
    input wire logic receiveBufferFull,
    input wire logic clearToSendChange,

    // Underrun event and status reset command, pulses.
    input wire logic spiUnderrunEvent,
    input wire logic resetStatusCmd,

    // Flag and request outputs.
    output logic underrunFlag,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Mode decoding.

    // True while the mode field selects SPI master or SPI slave.
    function automatic logic isSpi(input logic [3:0] mode);
        return (mode == `MODE_SPI_MASTER) || (mode == `MODE_SPI_SLAVE);
    endfunction

    // Bits that carry a source in the selected layout.
    function automatic logic [31:0] liveBits(input logic spi);
        // Buffer end, empty and full bits sit in both masks.
        return spi ? `SPI_USED_BITS : `CHAR_USED_BITS;
    endfunction

    // True when a write to the given address is an accepted write to that register.
    function automatic logic hitWrite(
        input logic strobe,
        input logic [31:0] addr,
        input logic [31:0] target
    );
        return strobe && (addr == target);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations.

    ctrl_state_s state;
    ctrl_state_s next_state;

    logic spiSel;
    logic [31:0] live;
    logic [31:0] srcVec;
    logic [31:0] eventSet;
    logic [31:0] eventClear;
    logic [31:0] events;
    logic [31:0] readValue;
    logic writeStrobe;
    logic [31:0] writeBits;
    logic underrunSet;
    logic underrunClear;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus front end.

    avalon_reg_port busPort (
        .clk(clk),
        .resetn(resetn),
        .read(read),
        .write(write),
        .writedata(writedata),
        .byteenable(byteenable),
        .readdata(readdata),
        .waitrequest(waitrequest),
        .readValue(readValue),
        .writeStrobe(writeStrobe),
        .writeBits(writeBits)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Underrun flag.

    // The flag records any underrun, whatever the mode, so that a mode change
    // cannot hide an error that has already happened.
    assign underrunSet = spiUnderrunEvent;
    assign underrunClear = resetStatusCmd;

    sticky_bits #(
        .WIDTH(1)
    ) underrunReg (
        .clk(clk),
        .resetn(resetn),
        .setBits(underrunSet),
        .clearBits(underrunClear),
        .bits(underrunFlag)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Event latches.

    // Rising edges of live sources are caught here so that software still sees a
    // source that came and went between two polls. Write one to clear.
    sticky_bits #(
        .WIDTH(32)
    ) eventReg (
        .clk(clk),
        .resetn(resetn),
        .setBits(eventSet),
        .clearBits(eventClear),
        .bits(events)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Source placement, decode and next state.

    always_comb begin
        next_state = state;
        spiSel = isSpi(usartMode);
        live = liveBits(spiSel);

        srcVec = `WORD_ZERO;
        srcVec[`BIT_RX_READY] = receiverReady;
        srcVec[`BIT_TX_READY] = transmitterReady;
        srcVec[`BIT_RX_BREAK] = receiveBreak;
        srcVec[`BIT_RX_BUF_END] = receiveBufferEnd;
        srcVec[`BIT_TX_BUF_END] = transmitBufferEnd;
        srcVec[`BIT_OVERRUN] = overrun;
        srcVec[`BIT_STOP_ERR] = stopBitError;
        srcVec[`BIT_PARITY_ERR] = parityError;
        srcVec[`BIT_RX_TIMEOUT] = rxIdleTimeout;
        srcVec[`BIT_TX_EMPTY] = transmitterEmpty;
        srcVec[`BIT_UNDERRUN] = underrunFlag;
        srcVec[`BIT_TX_BUF_EMPTY] = transmitBufferEmpty;
        srcVec[`BIT_RX_BUF_FULL] = receiveBufferFull;
        srcVec[`BIT_CTS_CHANGE] = clearToSendChange;
        // Sources without a place in the current layout never reach the request.
        srcVec = srcVec & live;

        eventSet = srcVec & ~state.prevSrc;
        eventClear = hitWrite(writeStrobe, address, `OFS_EVENT_CLEAR) ?
            writeBits : `WORD_ZERO;
        next_state.prevSrc = srcVec;

        // Bits with no source in the current layout ignore both ports, so a
        // masked value survives a trip through the other layout.
        if (hitWrite(writeStrobe, address, `OFS_ENABLE_SET)) begin
            next_state.mask = state.mask | (writeBits & live);
        end else if (hitWrite(writeStrobe, address, `OFS_ENABLE_CLEAR)) begin
            next_state.mask = state.mask & ~(writeBits & live);
        end

        case (address)
            `OFS_MASK_IMAGE: begin
                readValue = state.mask & live;
            end
            `OFS_EVENT_STATUS: begin
                readValue = events;
            end
            default: begin
                // Write-only ports and unmapped words read as zero.
                readValue = `WORD_ZERO;
            end
        endcase

        // Registered so that the request line is free of decode glitches; it costs
        // one cycle of latency after a flag or the mask changes.
        next_state.irq = |((srcVec | (events & live)) & state.mask & live);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= '{mask: `MASK_RESET, prevSrc: `WORD_ZERO, irq: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign irq = state.irq;

endmodule

// >>> usart_irq_cfg.svh
// Purpose: Constants of the serial port interrupt mask block.
// Assumes: Byte addresses on a 32-bit Avalon-MM slave.
// Notes: Bit positions are shared by the set, clear and mask views.
`ifndef USART_IRQ_CFG_SVH
`define USART_IRQ_CFG_SVH

`define OFS_ENABLE_SET 32'h4002_4008
`define OFS_ENABLE_CLEAR 32'h4002_400c
`define OFS_MASK_IMAGE 32'h4002_4010
`define OFS_EVENT_STATUS 32'h4002_4100
`define OFS_EVENT_CLEAR 32'h4002_4104

`define MODE_SPI_MASTER 4'he
`define MODE_SPI_SLAVE 4'hf

`define BIT_RX_READY 0
`define BIT_TX_READY 1
`define BIT_RX_BREAK 2
`define BIT_RX_BUF_END 3
`define BIT_TX_BUF_END 4
`define BIT_OVERRUN 5
`define BIT_STOP_ERR 6
`define BIT_PARITY_ERR 7
`define BIT_RX_TIMEOUT 8
`define BIT_TX_EMPTY 9
`define BIT_UNDERRUN 10
`define BIT_TX_BUF_EMPTY 11
`define BIT_RX_BUF_FULL 12
`define BIT_CTS_CHANGE 19

`define CHAR_USED_BITS 32'h0008_1bff
`define SPI_USED_BITS 32'h0000_1e3b
`define MASK_RESET 32'h0000_0000
`define WORD_ZERO 32'h0000_0000

`endif

// >>> usart_irq_pkg.sv
// Purpose: Types shared by the interrupt mask block.
// Assumes: Constants come from usart_irq_cfg.svh.
// Notes: Each design module keeps all of its state in one packed struct.
package usart_irq_pkg;

    typedef enum logic [1:0] {
        PORT_IDLE = 2'b01,
        PORT_ANSWER = 2'b10
    } port_phase_e;

    typedef struct packed {
        port_phase_e phase;
        logic [31:0] readdata;
    } port_state_s;

    typedef struct packed {
        logic [31:0] mask;
        logic [31:0] prevSrc;
        logic irq;
    } ctrl_state_s;

endpackage

// >>> sticky_bits.sv
// Purpose: A row of sticky flags with a set and a clear vector.
// Assumes: Set and clear are single-cycle vectors from the same clock.
// Notes: A set and a clear in the same cycle leave the flag set.
`timescale 1ns/1ps
module sticky_bits #(
    parameter int WIDTH = 32
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Flag control.
    input wire logic [WIDTH-1:0] setBits,
    input wire logic [WIDTH-1:0] clearBits,
    // Flag image.
    output logic [WIDTH-1:0] bits
);
    typedef struct packed {
        logic [WIDTH-1:0] bits;
    } sticky_state_s;

    sticky_state_s state;
    sticky_state_s next_state;

    always_comb begin
        next_state = state;
        // The set term is applied last so that an event is never lost to a clear.
        next_state.bits = (state.bits & ~clearBits) | setBits;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign bits = state.bits;
endmodule

// >>> avalon_reg_port.sv
// Purpose: Avalon-MM slave front end with one wait state per access.
// Assumes: The master holds its request until waitrequest is seen low.
// Notes: Write data is returned with disabled byte lanes forced to zero.
`timescale 1ns/1ps
`include "usart_irq_cfg.svh"
module avalon_reg_port import usart_irq_pkg::*; (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Avalon-MM slave.
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Register side.
    input wire logic [31:0] readValue,
    output logic writeStrobe,
    output logic [31:0] writeBits
);
    port_state_s state;
    port_state_s next_state;

    always_comb begin
        next_state = state;
        writeBits = `WORD_ZERO;
        for (int i = 0; i < 4; i++) begin
            writeBits[i*8 +: 8] = byteenable[i] ? writedata[i*8 +: 8] : 8'h00;
        end
        case (state.phase)
            PORT_IDLE: begin
                if (read || write) begin
                    next_state.phase = PORT_ANSWER;
                    // Read data is captured here so that it stands when waitrequest drops.
                    next_state.readdata = read ? readValue : `WORD_ZERO;
                end
            end
            PORT_ANSWER: begin
                next_state.phase = PORT_IDLE;
            end
            default: begin
                next_state.phase = PORT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= '{phase: PORT_IDLE, readdata: `WORD_ZERO};
        end else begin
            state <= next_state;
        end
    end

    assign waitrequest = (read || write) && (state.phase != PORT_ANSWER);
    assign writeStrobe = write && (state.phase == PORT_ANSWER);
    assign readdata = state.readdata;
endmodule

// >>> usart_irq_checker.sv
// Purpose: Bus and interrupt assertions for the mask block.
// Assumes: One clock and a synchronous active-low reset.
// Notes: A shadow mask is rebuilt from completed writes.
`timescale 1ns/1ps
`include "usart_irq_cfg.svh"
module usart_irq_checker (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Register bus.
    input wire logic [31:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Mode, underrun and request.
    input wire logic [3:0] usartMode,
    input wire logic spiUnderrunEvent,
    input wire logic resetStatusCmd,
    input wire logic underrunFlag,
    input wire logic irq
);
    ////////////////////////////////////////
    logic [31:0] shadow;
    logic [31:0] live;
    logic [31:0] lanes;
    logic [31:0] shadowLive;
    logic done;
    assign live = (usartMode >= 4'he) ? 32'h0000_1e3b : 32'h0008_1bff;
    assign lanes = {{8{byteenable[3]}}, {8{byteenable[2]}},
        {8{byteenable[1]}}, {8{byteenable[0]}}};
    assign done = write && !waitrequest;
    assign shadowLive = shadow & live;
    // Bits outside the current layout keep their value, so a mode swap cannot lose them.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            shadow <= 32'h0000_0000;
        end else if (done && address == `OFS_ENABLE_SET) begin
            shadow <= shadow | (writedata & lanes & live);
        end else if (done && address == `OFS_ENABLE_CLEAR) begin
            shadow <= shadow & ~(writedata & lanes & live);
        end
    end
    ////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("access took more than one wait state");
    a_wait_first: assert property ($rose(read) |-> waitrequest)
        else $error("read answered without a wait state");
    a_image_read: assert property (read && !waitrequest && address == `OFS_MASK_IMAGE
        |-> readdata == shadowLive)
        else $error("mask image differs from shadow");
    a_unmapped_zero: assert property (read && !waitrequest && address != `OFS_MASK_IMAGE
        && address != `OFS_EVENT_STATUS |-> readdata == 32'h0)
        else $error("unreadable address returned data");
    a_irq_raise: assert property (live[10] && shadow[10] && underrunFlag |=> irq)
        else $error("enabled underrun gave no request");
    a_irq_masked: assert property (irq |-> $past(shadowLive) != 32'h0)
        else $error("request with no enabled source");
    a_underrun_set: assert property (spiUnderrunEvent |=> underrunFlag)
        else $error("underrun flag not set");
    a_underrun_hold: assert property (underrunFlag && !resetStatusCmd
        |=> underrunFlag)
        else $error("underrun flag dropped early");
    a_underrun_clear: assert property (resetStatusCmd && !spiUnderrunEvent
        |=> !underrunFlag)
        else $error("underrun flag not cleared");
endmodule
bind usart_irq_mask_control usart_irq_checker chk (.clk(clk), .resetn(resetn),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .usartMode(usartMode), .spiUnderrunEvent(spiUnderrunEvent),
    .resetStatusCmd(resetStatusCmd), .underrunFlag(underrunFlag), .irq(irq));

// >>> testbench.sv
// Purpose: Self-checking bench of the interrupt mask block.
// Assumes: Avalon master with one request at a time.
// Notes: Status flags are driven as one vector by bit position.
`timescale 1ns/1ps
`include "usart_irq_cfg.svh"
module testbench;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [31:0] address = 32'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'hf;
    logic [3:0] usartMode = 4'h0;
    logic [31:0] src = 32'h0;
    logic spiUnderrunEvent = 1'b0;
    logic resetStatusCmd = 1'b0;
    logic [31:0] readdata;
    logic waitrequest;
    logic underrunFlag;
    logic irq;
    logic [31:0] rd;
    int bad_count = 0;
    int check_count = 0;
    int cycles = 0;
    // Each row: mode, set word, clear word, expected mask image.
    logic [99:0] rows [7] = '{
        {4'h0, 32'hffff_ffff, 32'h0, 32'h0008_1bff},
        {4'he, 32'hffff_ffff, 32'h0, 32'h0000_1e3b},
        {4'hf, 32'hffff_ffff, 32'h1, 32'h0000_1e3a},
        {4'h0, 32'h0008_0100, 32'h0, 32'h0008_0100},
        {4'he, 32'h0008_05c4, 32'h0, 32'h0000_0400},
        {4'h0, 32'h0000_18e0, 32'h0000_0840, 32'h0000_10a0},
        {4'hf, 32'h0000_1818, 32'h0000_0008, 32'h0000_1810}};
    always #2.5 clk = ~clk;
    usart_irq_mask_control dut (.clk(clk), .resetn(resetn), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .usartMode(usartMode), .receiverReady(src[0]),
        .transmitterReady(src[1]), .receiveBreak(src[2]), .receiveBufferEnd(src[3]),
        .transmitBufferEnd(src[4]), .overrun(src[5]), .stopBitError(src[6]),
        .parityError(src[7]), .rxIdleTimeout(src[8]), .transmitterEmpty(src[9]),
        .transmitBufferEmpty(src[11]), .receiveBufferFull(src[12]),
        .clearToSendChange(src[19]), .spiUnderrunEvent(spiUnderrunEvent),
        .resetStatusCmd(resetStatusCmd), .underrunFlag(underrunFlag), .irq(irq));
    ////////////////////////////////////////
    task close_out();
        $display("Checks %0d, errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // The run is a few hundred cycles, so this ceiling only trips on a hang.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            close_out();
        end
    end
    task chk32(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Waitrequest and read data are taken at the rising edge, where they still show the
    // settled values of the cycle before; the request is released only after that edge.
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        byteenable <= be;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask
    task rdchk(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hf);
        chk32(rd, exp);
    endtask
    task irqchk(input logic exp);
        @(posedge clk);
        chk32({31'h0, irq}, {31'h0, exp});
    endtask
    task clear_all();
        usartMode <= 4'h0;
        wr(`OFS_ENABLE_CLEAR, 32'hffff_ffff);
        usartMode <= 4'he;
        wr(`OFS_ENABLE_CLEAR, 32'hffff_ffff);
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            clear_all();
            usartMode <= rows[i][99:96];
            wr(`OFS_ENABLE_SET, rows[i][95:64]);
            wr(`OFS_ENABLE_CLEAR, rows[i][63:32]);
            rdchk(`OFS_MASK_IMAGE, rows[i][31:0]);
        end
        clear_all();
        usartMode <= 4'h0;
        wr(`OFS_ENABLE_SET, 32'h20);
        src <= 32'h20;
        irqchk(1'b0);
        irqchk(1'b1);
        rdchk(`OFS_EVENT_STATUS, 32'h20);
        wr(`OFS_ENABLE_CLEAR, 32'h20);
        // The request is registered, so it still stands for one cycle after the clear.
        irqchk(1'b1);
        irqchk(1'b0);
        src <= 32'h80;
        wr(`OFS_EVENT_CLEAR, 32'h20);
        rdchk(`OFS_EVENT_STATUS, 32'h80);
        irqchk(1'b0);
        src <= 32'h0;
        usartMode <= 4'he;
        wr(`OFS_EVENT_CLEAR, 32'hffff_ffff);
        src <= 32'h4;
        wr(`OFS_ENABLE_SET, 32'h4);
        rdchk(`OFS_EVENT_STATUS, 32'h0);
        irqchk(1'b0);
        spiUnderrunEvent <= 1'b1;
        @(posedge clk);
        spiUnderrunEvent <= 1'b0;
        irqchk(1'b0);
        chk32({31'h0, underrunFlag}, 32'h1);
        wr(`OFS_ENABLE_SET, 32'h400);
        irqchk(1'b0);
        irqchk(1'b1);
        rdchk(`OFS_EVENT_STATUS, 32'h400);
        resetStatusCmd <= 1'b1;
        @(posedge clk);
        resetStatusCmd <= 1'b0;
        // The latched underrun event keeps the request up until it is cleared as well.
        wr(`OFS_EVENT_CLEAR, 32'h400);
        irqchk(1'b1);
        irqchk(1'b0);
        chk32({31'h0, underrunFlag}, 32'h0);
        rdchk(`OFS_ENABLE_SET, 32'h0);
        rdchk(32'h4002_4020, 32'h0);
        clear_all();
        usartMode <= 4'h0;
        bus(1'b1, `OFS_ENABLE_SET, 32'h1818, 4'h1);
        rdchk(`OFS_MASK_IMAGE, 32'h18);
        wr(`OFS_ENABLE_SET, 32'h100);
        usartMode <= 4'hf;
        rdchk(`OFS_MASK_IMAGE, 32'h18);
        usartMode <= 4'h0;
        rdchk(`OFS_MASK_IMAGE, 32'h118);
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        rdchk(`OFS_MASK_IMAGE, 32'h0);
        irqchk(1'b0);
        close_out();
    end
endmodule
